// >>> hw/rxbic_top.sv
// receive backplane interface control with axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
`include "rxbic_consts.svh"
module rxbic_top
(
   // system
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // axi4-lite write
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   // axi4-lite read
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // link domain
   input  wire logic        LINK_CLK,
   input  wire logic [3:0]  LINE_DATA,
   input  wire logic        LINE_SIG,
   input  wire logic        TX_DATA,
   output logic             TX_LINE_DATA,
   // receive backplane
   output logic             RX_SERIAL_DATA,
   input  wire logic        RX_SERIAL_CLOCK_I,
   output logic             RX_SERIAL_CLOCK_O,
   output logic             RX_SERIAL_CLOCK_OE_N,
   input  wire logic        RX_FRAME_SYNC_I,
   output logic             RX_FRAME_SYNC_O,
   output logic             RX_FRAME_SYNC_OE_N,
   output logic             RX_SIGNALING_OUT,
   output logic             RX_RECOVERED_CLOCK
);
   // -------------------------------------------------------------------
   // register bus
   // -------------------------------------------------------------------
   rxbic_pkg::rxbic_ctrl_t ctrl;
   rxbic_pkg::rxbic_ctrl_t next_ctrl;
   rxbic_pkg::rxbic_pat_t  pat;
   rxbic_pkg::rxbic_pat_t  next_pat;
   logic                   drive;
   logic                   next_drive;
   logic                   aw_full;
   logic                   next_aw_full;
   logic [7:0]             aw_addr;
   logic [7:0]             next_aw_addr;
   logic                   w_full;
   logic                   next_w_full;
   logic [31:0]            w_data;
   logic [31:0]            next_w_data;
   logic                   w_strb0;
   logic                   next_w_strb0;
   logic                   bvalid;
   logic                   next_bvalid;
   logic [1:0]             bresp;
   logic [1:0]             next_bresp;
   logic                   rvalid;
   logic                   next_rvalid;
   logic [31:0]            rdata;
   logic [31:0]            next_rdata;
   logic [1:0]             rresp;
   logic [1:0]             next_rresp;
   logic [1:0]             frame_sync_c;
   logic                   do_write;

   assign AWREADY = !aw_full && !bvalid;
   assign WREADY  = !w_full && !bvalid;
   assign ARREADY = !rvalid;
   assign BVALID  = bvalid;
   assign BRESP   = bresp;
   assign RVALID  = rvalid;
   assign RDATA   = rdata;
   assign RRESP   = rresp;
   assign do_write = aw_full && w_full && !bvalid;

   always_comb
   begin
      next_ctrl    = ctrl;
      next_pat     = pat;
      next_drive   = drive;
      next_aw_full = aw_full;
      next_aw_addr = aw_addr;
      next_w_full  = w_full;
      next_w_data  = w_data;
      next_w_strb0 = w_strb0;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (AWVALID && AWREADY)
      begin
         next_aw_full = 1'b1;
         next_aw_addr = AWADDR;
      end
      if (WVALID && WREADY)
      begin
         next_w_full  = 1'b1;
         next_w_data  = WDATA;
         next_w_strb0 = WSTRB[0];
      end
      if (do_write)
      begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = `RXBIC_RESP_OKAY;
         // reserved bit 6 never stored
         unique case (aw_addr)
            `RXBIC_ADDR_CTRL:
               if (w_strb0)
               begin
                  next_ctrl = w_data[7:0] & `RXBIC_CTRL_WMASK;
               end
            `RXBIC_ADDR_PAT:
               if (w_strb0)
               begin
                  next_pat = w_data[7:0] & `RXBIC_PAT_WMASK;
               end
            `RXBIC_ADDR_LINK:
               if (w_strb0)
               begin
                  next_drive = w_data[`RXBIC_LINK_DRIVE_BIT];
               end
            default:
               next_bresp = `RXBIC_RESP_SLVERR;
         endcase
      end
      else if (bvalid && BREADY)
      begin
         next_bvalid = 1'b0;
      end
      if (ARVALID && ARREADY)
      begin
         next_rvalid = 1'b1;
         next_rresp  = `RXBIC_RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         unique case (ARADDR)
            `RXBIC_ADDR_CTRL: next_rdata[7:0] = ctrl;
            `RXBIC_ADDR_PAT:  next_rdata[7:0] = pat;
            `RXBIC_ADDR_LINK:
            begin
               next_rdata[`RXBIC_LINK_DRIVE_BIT] = drive;
               next_rdata[`RXBIC_LINK_FRAME_BIT] = frame_sync_c[1];
            end
            default: next_rresp = `RXBIC_RESP_SLVERR;
         endcase
      end
      else if (rvalid && RREADY)
      begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         ctrl    <= `RXBIC_CTRL_RESET;
         pat     <= `RXBIC_PAT_RESET;
         drive   <= `RXBIC_LINK_RESET;
         aw_full <= 1'b0;
         aw_addr <= 8'h00;
         w_full  <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_strb0 <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= `RXBIC_RESP_OKAY;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `RXBIC_RESP_OKAY;
      end
      else
      begin
         ctrl    <= next_ctrl;
         pat     <= next_pat;
         drive   <= next_drive;
         aw_full <= next_aw_full;
         aw_addr <= next_aw_addr;
         w_full  <= next_w_full;
         w_data  <= next_w_data;
         w_strb0 <= next_w_strb0;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end

   // -------------------------------------------------------------------
   // crossings
   // -------------------------------------------------------------------
   rxbic_pkg::rxbic_cfg_t cfg_c;
   rxbic_pkg::rxbic_cfg_t cfg_m;
   rxbic_pkg::rxbic_cfg_t cfg;
   logic [1:0]            rst_m;
   logic                  l_rst_n;
   logic [2:0]            sclk_s;
   logic [1:0]            fsync_s;
   logic                  frame_tgl;

   assign cfg_c = '{ctrl: ctrl, pat: pat, drive: drive};
   assign l_rst_n = rst_m[1];

   // static settings, each bit through two flops
   for (genvar i = 0; i < $bits(cfg_c); i++)
   begin : g_cfg_sync
      always_ff @(posedge LINK_CLK)
      begin
         cfg_m[i] <= cfg_c[i];
         cfg[i]   <= cfg_m[i];
      end
   end

   always_ff @(posedge LINK_CLK)
   begin
      rst_m   <= {rst_m[0], RST_N};
      sclk_s  <= {sclk_s[1:0], RX_SERIAL_CLOCK_I};
      fsync_s <= {fsync_s[0], RX_FRAME_SYNC_I};
   end

   // frame toggle back to the register side
   always_ff @(posedge CLK)
   begin
      frame_sync_c <= {frame_sync_c[0], frame_tgl};
   end

   // -------------------------------------------------------------------
   // link side
   // -------------------------------------------------------------------
   logic       base;
   logic       drv;
   logic       rise_ev;
   logic       fall_ev;
   logic       launch;
   logic       overhead;
   logic       pat_bp;
   logic       pat_line;
   logic       sig_en;
   logic       prbs_bit;
   logic       ser_src;
   logic [9:0] last;
   logic [7:0] slot_bit;
   logic       ph;
   logic       next_ph;
   logic [9:0] cnt;
   logic [9:0] next_cnt;
   logic       ser;
   logic       next_ser;
   logic       tx;
   logic       next_tx;
   logic       sclk_o;
   logic       next_sclk_o;
   logic       fsync_o;
   logic       next_fsync_o;
   logic       next_frame_tgl;
   logic       sig;
   logic       next_sig;
   logic       rec_ph;
   logic       next_rec_ph;
   logic       rec;
   logic       next_rec;

   always_comb
   begin
      base     = cfg.ctrl.rate == `RXBIC_RATE_BASE;
      drv      = base && cfg.drive;
      rise_ev  = drv ? !ph : (sclk_s[1] && !sclk_s[2]);
      fall_ev  = drv ? ph : (!sclk_s[1] && sclk_s[2]);
      launch   = (base && !cfg.ctrl.mux && cfg.ctrl.inv)
               ? fall_ev : rise_ev;
      last     = cfg.ctrl.mux ? `RXBIC_MUX_FRAME_LAST
                              : `RXBIC_FRAME_LAST;
      slot_bit = cfg.ctrl.mux ? cnt[9:2] : cnt[7:0];
      overhead = slot_bit < `RXBIC_OVERHEAD_BITS;
      pat_bp   = cfg.pat.unframed && cfg.pat.sw;
      pat_line = cfg.pat.unframed && !cfg.pat.sw;
      sig_en   = !base || cfg.ctrl.mux || cfg.ctrl.frac;
      ser_src  = pat_bp ? prbs_bit
               : (cfg.ctrl.mux ? LINE_DATA[cnt[1:0]]
                               : LINE_DATA[0]);
      next_ph = drv ? !ph : 1'b0;
      next_cnt = cnt;
      if (!drv && fsync_s[1])
      begin
         next_cnt = 10'h000;
      end
      else if (rise_ev)
      begin
         next_cnt = (cnt == last) ? 10'h000 : cnt + 10'h001;
      end
      next_ser = launch ? ser_src : ser;
      next_tx  = rise_ev ? (pat_line ? prbs_bit : TX_DATA) : tx;
      // gaps over overhead bits in payload mode
      next_sclk_o    = next_ph && !(cfg.ctrl.pl_gate && overhead);
      next_fsync_o   = drv && rise_ev && (cnt == last);
      next_frame_tgl = (rise_ev && (cnt == last)) ? !frame_tgl
                                                  : frame_tgl;
      next_sig    = sig_en && LINE_SIG;
      next_rec_ph = !rec_ph;
      next_rec    = sig_en && !rec_ph;
   end

   always_ff @(posedge LINK_CLK)
   begin
      if (!l_rst_n)
      begin
         ph        <= 1'b0;
         cnt       <= 10'h000;
         ser       <= 1'b0;
         tx        <= 1'b0;
         sclk_o    <= 1'b0;
         fsync_o   <= 1'b0;
         frame_tgl <= 1'b0;
         sig       <= 1'b0;
         rec_ph    <= 1'b0;
         rec       <= 1'b0;
      end
      else
      begin
         ph        <= next_ph;
         cnt       <= next_cnt;
         ser       <= next_ser;
         tx        <= next_tx;
         sclk_o    <= next_sclk_o;
         fsync_o   <= next_fsync_o;
         frame_tgl <= next_frame_tgl;
         sig       <= next_sig;
         rec_ph    <= next_rec_ph;
         rec       <= next_rec;
      end
   end

   rxbic_pattern_gen u_pattern
   (
      .clk     (LINK_CLK),
      .rst_n   (l_rst_n),
      .advance (rise_ev && cfg.pat.unframed),
      .bit_out (prbs_bit)
   );

   assign TX_LINE_DATA         = tx;
   assign RX_SERIAL_DATA       = ser;
   assign RX_SERIAL_CLOCK_O    = sclk_o;
   assign RX_SERIAL_CLOCK_OE_N = !drv;
   assign RX_FRAME_SYNC_O      = fsync_o;
   assign RX_FRAME_SYNC_OE_N   = !drv;
   assign RX_SIGNALING_OUT     = sig;
   assign RX_RECOVERED_CLOCK   = rec;

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   property p_tx_pattern;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      rise_ev && pat_line |=> tx == $past(prbs_bit);
   endproperty
   a_tx_pattern: assert property (p_tx_pattern)
      else $error("line output not carrying pattern");

   property p_bp_pattern;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      launch && pat_bp |=> ser == $past(prbs_bit);
   endproperty
   a_bp_pattern: assert property (p_bp_pattern)
      else $error("backplane not carrying pattern");

   property p_clk_cont;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      drv && !cfg.ctrl.pl_gate |=> sclk_o == ph;
   endproperty
   a_clk_cont: assert property (p_clk_cont)
      else $error("serial clock not continuous");

   property p_clk_gap;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      drv && cfg.ctrl.pl_gate && overhead |=> !sclk_o;
   endproperty
   a_clk_gap: assert property (p_clk_gap)
      else $error("clock pulse during overhead");

   property p_sig_off;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      base && !cfg.ctrl.mux && !cfg.ctrl.frac |=> !sig && !rec;
   endproperty
   a_sig_off: assert property (p_sig_off)
      else $error("signaling output active while disabled");

   property p_sig_on;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      !base || cfg.ctrl.mux |=> sig == $past(LINE_SIG);
   endproperty
   a_sig_on: assert property (p_sig_on)
      else $error("signaling output not following input");

   property p_inv_hold;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      drv && !cfg.ctrl.mux && cfg.ctrl.inv && !ph |=> $stable(ser);
   endproperty
   a_inv_hold: assert property (p_inv_hold)
      else $error("data changed at rising edge while inverted");

   property p_inv_hs;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      (!base || cfg.ctrl.mux) && rise_ev |=> ser == $past(ser_src);
   endproperty
   a_inv_hs: assert property (p_inv_hs)
      else $error("inversion acted outside base rate");

   property p_mux;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      cfg.ctrl.mux && launch && !pat_bp
         |=> ser == $past(LINE_DATA[cnt[1:0]]);
   endproperty
   a_mux: assert property (p_mux)
      else $error("wrong channel interleaved");

   property p_mux_wrap;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      cfg.ctrl.mux && rise_ev && cnt == 10'h3FF |=> cnt == 10'h000;
   endproperty
   a_mux_wrap: assert property (p_mux_wrap)
      else $error("multiplexed frame length wrong");

   property p_rate_in;
      @(posedge LINK_CLK) disable iff (!l_rst_n)
      !base |-> RX_SERIAL_CLOCK_OE_N && RX_FRAME_SYNC_OE_N;
   endproperty
   a_rate_in: assert property (p_rate_in)
      else $error("clock driven at high rate");

   property p_rsv;
      @(posedge CLK) disable iff (!RST_N)
      do_write |=> !ctrl.rsv6;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved bit stored");

   c_mux_frame: cover property (@(posedge LINK_CLK) disable iff (!l_rst_n)
      cfg.ctrl.mux && rise_ev && cnt == 10'h3FF);
   c_gap: cover property (@(posedge LINK_CLK) disable iff (!l_rst_n)
      drv && cfg.ctrl.pl_gate && overhead && rise_ev);
   c_pat_bp: cover property (@(posedge LINK_CLK) disable iff (!l_rst_n)
      launch && pat_bp);
endmodule : rxbic_top
`default_nettype wire

// >>> shared/rxbic_consts.svh
// register map, field positions, reset values and frame counts
`ifndef RXBIC_CONSTS_SVH
`define RXBIC_CONSTS_SVH
// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define RXBIC_ADDR_CTRL       8'h00
`define RXBIC_ADDR_PAT        8'h04
`define RXBIC_ADDR_LINK       8'h08
// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define RXBIC_CTRL_RESET      8'h00
`define RXBIC_PAT_RESET       8'h00
`define RXBIC_LINK_RESET      1'h0
`define RXBIC_CTRL_WMASK      8'hBF
`define RXBIC_PAT_WMASK       8'h09
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RXBIC_LINK_DRIVE_BIT  0
`define RXBIC_LINK_FRAME_BIT  8
// ----------------------------------------------------------------------
// encodings and frame structure
// ----------------------------------------------------------------------
`define RXBIC_RATE_BASE       2'h0
`define RXBIC_FRAME_LAST      10'h0FF
`define RXBIC_MUX_FRAME_LAST  10'h3FF
`define RXBIC_OVERHEAD_BITS   8'h08
`define RXBIC_PRBS_SEED       15'h7FFF
`define RXBIC_RESP_OKAY       2'h0
`define RXBIC_RESP_SLVERR     2'h2
`endif

// >>> shared/rxbic_pkg.sv
// types shared by the receive backplane interface control block
`default_nettype none
package rxbic_pkg;
   typedef struct packed {
      logic       sync_rsv;
      logic       rsv6;
      logic       pl_gate;
      logic       frac;
      logic       inv;
      logic       mux;
      logic [1:0] rate;
   } rxbic_ctrl_t;

   typedef struct packed {
      logic [3:0] rsv_hi;
      logic       sw;
      logic [1:0] rsv_lo;
      logic       unframed;
   } rxbic_pat_t;

   typedef struct packed {
      rxbic_ctrl_t ctrl;
      rxbic_pat_t  pat;
      logic        drive;
   } rxbic_cfg_t;
endpackage : rxbic_pkg
`default_nettype wire

// >>> hw/rxbic_pattern_gen.sv
// unframed test pattern generator, 15-stage lfsr
`timescale 1ns/10ps
`default_nettype none
`include "rxbic_consts.svh"
module rxbic_pattern_gen
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // control
   input  wire logic advance,
   // pattern
   output logic      bit_out
);
   logic [14:0] lfsr;
   logic [14:0] next_lfsr;

   always_comb
   begin
      next_lfsr = lfsr;
      if (advance)
      begin
         next_lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         lfsr <= `RXBIC_PRBS_SEED;
      end
      else
      begin
         lfsr <= next_lfsr;
      end
   end

   assign bit_out = lfsr[14];
endmodule : rxbic_pattern_gen
`default_nettype wire

// >>> test/rxbic_bp_model.sv
// backplane logic model: clocks the device while run is set and its clock output is disabled, samples its data
`timescale 1ns/10ps
`default_nettype none
module rxbic_bp_model
(
   // control
   input  wire logic link_clk,
   input  wire logic run,
   // device pins
   input  wire logic ser_data,
   input  wire logic clk_o,
   input  wire logic clk_oe_n,
   input  wire logic sync_o,
   input  wire logic sync_oe_n,
   // resolved pins and sample counts
   output logic      clk_pin,
   output logic      sync_pin,
   output var int    ones,
   output var int    bits
);
   logic [2:0] div = 3'h0;
   initial ones = 0;
   initial bits = 0;
   always @(posedge link_clk) div <= div + 3'h1;
   // own clock stands still unless run; device drives when enabled
   assign clk_pin = clk_oe_n ? (run & div[2]) : clk_o;
   assign sync_pin = sync_oe_n ? 1'b0 : sync_o;
   // one bit taken at each rising clock edge
   always @(posedge clk_pin)
   begin
      bits <= bits + 1;
      ones <= ones + int'(ser_data);
   end
endmodule : rxbic_bp_model
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the receive backplane interface control block
`timescale 1ns/10ps
`default_nettype none
`include "rxbic_consts.svh"
module tb;
   logic        clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [3:0]  line_data = 4'h0;
   logic        line_sig = 1'b0;
   logic        bp_run = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, sdata, prev;
   logic        sclk_o, sclk_oe_n, sclk_i, sync_o, sync_oe_n, sync_i;
   logic        sig, rclk, txl;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [33:0] e;
   logic [33:0] q[$];
   int          cnt[8];
   int          ones, bits, o0, b0, pc;
   int          err_total = 0;
   int          checks_done = 0;
   int          seed = 32'h9E27;

   rxbic_top u_dut
   (
      .CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .LINE_DATA(line_data), .LINE_SIG(line_sig), .TX_DATA(1'b0),
      .TX_LINE_DATA(txl), .RX_SERIAL_DATA(sdata),
      .RX_SERIAL_CLOCK_I(sclk_i), .RX_SERIAL_CLOCK_O(sclk_o),
      .RX_SERIAL_CLOCK_OE_N(sclk_oe_n), .RX_FRAME_SYNC_I(sync_i),
      .RX_FRAME_SYNC_O(sync_o), .RX_FRAME_SYNC_OE_N(sync_oe_n),
      .RX_SIGNALING_OUT(sig), .RX_RECOVERED_CLOCK(rclk)
   );
   rxbic_bp_model u_bp
   (
      .link_clk(link_clk), .run(bp_run), .ser_data(sdata),
      .clk_o(sclk_o), .clk_oe_n(sclk_oe_n), .sync_o(sync_o),
      .sync_oe_n(sync_oe_n), .clk_pin(sclk_i), .sync_pin(sync_i),
      .ones(ones), .bits(bits)
   );

   always #50 clk = ~clk;
   initial
   begin
      #7;
      forever #40 link_clk = ~link_clk;
   end
   // cnt: 0 clock rises, 1 recovered rises, 2 signaling, 3 tx, 4 rx,
   // 5 data edges with clock high, 6 with clock low, 7 frame sync pulses
   always @(posedge sclk_o) cnt[0]++;
   always @(posedge sync_o) cnt[7]++;
   always @(posedge rclk) cnt[1]++;
   always @(posedge link_clk) line_sig <= 1'($random(seed));
   always @(negedge link_clk)
   begin
      cnt[2] += int'(sig);
      cnt[3] += int'(txl);
      cnt[4] += int'(sdata);
      cnt[5] += int'(sdata !== prev && sclk_o);
      cnt[6] += int'(sdata !== prev && !sclk_o);
      prev = sdata;
   end
   always @(negedge clk)
   begin
      if (rvalid && rready)
      begin
         e = q.pop_front();
         chk("rdata", e[31:0], rdata);
         chk("rresp", {30'h0, e[33:32]}, {30'h0, rresp});
      end
   end

   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      checks_done++;
      if (g !== x)
      begin
         $display("mismatch %s expected %0h seen %0h", nm, x, g);
         err_total++;
      end
   endtask : chk
   task automatic rng(input string nm, input int v, input int lo,
                      input int hi);
      chk(nm, 32'h1, {31'h0, v >= lo && v <= hi});
   endtask : rng
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int         t;
      logic       aw;
      logic       w;
      logic       b;
      logic [1:0] r;
      t = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge clk);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw)
            awvalid <= 1'b0;
         if (w)
            wvalid <= 1'b0;
         t++;
      end while (!b && t < 40);
      bready <= 1'b0;
      chk("bvalid", 32'h1, {31'h0, b});
      chk("bresp", 32'h0, {30'h0, r});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] x);
      int   t;
      logic ar;
      logic r;
      t = 0;
      @(posedge clk);
      q.push_back(x);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge clk);
         ar = arvalid & arready;
         r = rvalid;
         @(posedge clk);
         if (ar)
            arvalid <= 1'b0;
         t++;
      end while (!r && t < 40);
      rready <= 1'b0;
      chk("rvalid", 32'h1, {31'h0, r});
   endtask : rd
   task automatic span(input int n);
      repeat (12) @(posedge link_clk);
      cnt = '{default: 0};
      o0 = ones;
      b0 = bits;
      repeat (n) @(posedge link_clk);
      @(posedge clk);
   endtask : span
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      #2_000_000;
      err_total++;
      tally_and_finish();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(`RXBIC_ADDR_CTRL, 34'h0);
      wr(`RXBIC_ADDR_CTRL, 32'h3F);
      rd(`RXBIC_ADDR_CTRL, 34'h3F);
      wr(`RXBIC_ADDR_PAT, 32'hFF);
      rd(`RXBIC_ADDR_PAT, 34'h09);
      rd(8'h0C, {2'h2, 32'h0});
      wr(`RXBIC_ADDR_PAT, 32'h0);
      $display("test registers done");
      wr(`RXBIC_ADDR_CTRL, 32'h0);
      wr(`RXBIC_ADDR_LINK, 32'h1);
      span(512);
      chk("oe_n", 32'h0, {31'h0, sclk_oe_n});
      chk("sync_oe_n", 32'h0, {31'h0, sync_oe_n});
      rng("fsync", cnt[7], 1, 2);
      rng("sclk", cnt[0], 255, 257);
      rng("rclk", cnt[1], 0, 0);
      rng("sig", cnt[2], 0, 0);
      wr(`RXBIC_ADDR_CTRL, 32'h20);
      span(512);
      rng("gapped", cnt[0], 247, 249);
      wr(`RXBIC_ADDR_CTRL, 32'h10);
      span(512);
      rng("rclk", cnt[1], 255, 257);
      rng("sig", cnt[2], 150, 362);
      bp_run <= 1'b1;
      wr(`RXBIC_ADDR_CTRL, 32'h09);
      span(512);
      chk("oe_n", 32'h1, {31'h0, sclk_oe_n});
      chk("sync_oe_n", 32'h1, {31'h0, sync_oe_n});
      rng("fsync", cnt[7], 0, 0);
      rng("rclk", cnt[1], 255, 257);
      rng("sig", cnt[2], 150, 362);
      $display("test clocks done");
      bp_run <= 1'b0;
      wr(`RXBIC_ADDR_CTRL, 32'h0);
      wr(`RXBIC_ADDR_PAT, 32'h01);
      span(512);
      rng("tx", cnt[3], 1, 512);
      rng("rx", cnt[4], 0, 0);
      wr(`RXBIC_ADDR_PAT, 32'h09);
      span(512);
      rng("rx", cnt[4], 1, 512);
      rng("tx", cnt[3], 0, 0);
      rng("edge_lo", cnt[6], 0, 0);
      wr(`RXBIC_ADDR_CTRL, 32'h08);
      span(512);
      rng("edge_hi", cnt[5], 0, 0);
      rng("edge_lo", cnt[6], 1, 512);
      $display("test pattern done");
      wr(`RXBIC_ADDR_PAT, 32'h0);
      wr(`RXBIC_ADDR_LINK, 32'h0);
      wr(`RXBIC_ADDR_CTRL, 32'h0C);
      bp_run <= 1'b1;
      repeat (3)
      begin
         line_data <= 4'($random(seed));
         span(640);
         pc = $countones(line_data);
         rng("bits", bits - b0, 78, 82);
         rng("mux", (ones - o0) * 4 - pc * (bits - b0), -12, 12);
         rng("rclk", cnt[1], 319, 321);
      end
      $display("test multiplex done");
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
